// *** rtl/adcsq_top.sv ***
// Purpose: control of a successive-approximation converter: power, clock
//          choice, four-conversion sequences, completion flag, register port
// Assumes: core_clk is the bus clock; rc_osc_clk is sampled as a plain input
// Notes:   conversions tick on every core_clk or on rising rc_osc_clk edges
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
module adcsq_top
   import adcsq_pkg::*;
(
   // clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst_b,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wr_data,
   input  wire logic              wr_stb,
   input  wire logic              rd_stb,
   output logic      [DATA_W-1:0] rd_data,
   // alternate converter clock
   input  wire logic              rc_osc_clk,
   // analog side
   input  wire logic              comp_in,
   output logic      [CS_W-1:0]   mux_chan_q,
   output logic                   sample_q,
   output logic      [DATA_W-1:0] dac_code,
   output logic                   pump_en_q,
   output logic                   pump_tick_q,
   output logic                   nvm_pump_rc_q,
   output logic                   busy_q
);
   typedef struct packed {
      logic [DATA_W-1:0] opt;
      logic              scan;
      logic              multi_channel_select;
      logic [CS_W-1:0]   cs;
      logic              done;
      adcsq_state_t      st;
      logic [4:0]        cnt;
      logic [1:0]        idx;
      logic              rc_prev;
      logic              pump_tick;
      logic              sample;
      logic [CS_W-1:0]   mux;
      logic              busy;
      logic [5:0]        since;
      logic              rc_seen;
   } adcsq_main_t;

   localparam adcsq_main_t MAIN_RST = '{
      opt: OPT_RST, scan: CTL_RST[CTL_SCAN_BIT], multi_channel_select: CTL_RST[CTL_MULTI_CHANNEL_SELECT_BIT],
      cs: CTL_RST[CTL_CS_LSB +: CS_W], done: 1'h0, st: ST_IDLE, cnt: 5'h0,
      idx: 2'h0, rc_prev: 1'h0, pump_tick: 1'h0, sample: 1'h0, mux: 4'h0,
      busy: 1'h0, since: 6'h3f, rc_seen: 1'h0};

   adcsq_main_t       q;
   adcsq_main_t       d;
   adcsq_res_if       res ();
   adcsq_sar_if       sar ();
   logic              tick;
   logic              wr_opt;
   logic              wr_ctl;
   logic              conv_end;
   logic [ADDR_W-1:0] res_off;
   logic [4:0]        bit_off;

   adcsq_results u_results (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .res      (res.mem)
   );

   adcsq_sar u_sar (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .sar      (sar.sar)
   );

   // conversion tick: every bus cycle, or each rising RC edge; no rate is assumed
   assign tick = q.opt[OPT_CLOCK_SOURCE_SELECT_BIT] ? (rc_osc_clk && !q.rc_prev) : 1'h1;

   assign wr_opt = wr_stb && (addr == OPT_ADDR);
   assign wr_ctl = wr_stb && (addr == CTL_ADDR);
   assign res_off = ADDR_W'(addr - RES_BASE_ADDR);
   assign bit_off = 5'(q.cnt - 5'(SAMPLE_TICKS));

   // end of one channel: directly in bus mode, after the sync wait in RC mode
   assign conv_end = ((q.st == ST_CONV) && tick && (q.cnt == 5'(CONV_TICKS - 1))
                      && !q.opt[OPT_CLOCK_SOURCE_SELECT_BIT])
                     || ((q.st == ST_SYNC) && (q.cnt == 5'(SYNC_CYC - 1)));

   always_comb begin
      d = q;
      d.rc_prev = rc_osc_clk;
      d.pump_tick = tick && q.opt[OPT_PWR_BIT];
      sar.clr = 1'h0;
      sar.trial = 1'h0;
      sar.decide = 1'h0;
      sar.bit_idx = 3'(DATA_W - 1) - bit_off[3:1];
      sar.comp = comp_in;
      res.we = 1'h0;
      res.widx = q.idx;
      res.wdata = sar.code;
      // bus read: results are read-only words, options and control read back, unmapped addresses read zero
      res.rd_en = rd_stb;
      res.rd_res = rd_stb && (res_off < ADDR_W'(RES_NUM));
      res.ridx = res_off[1:0];
      if (addr == OPT_ADDR) begin
         res.other = q.opt;
      end else if (addr == CTL_ADDR) begin
         res.other = {q.done, 1'h0, q.scan, q.multi_channel_select, q.cs};
      end else begin
         res.other = '0;
      end

      unique case (q.st)
         ST_IDLE: begin
         end
         ST_LEAD: begin
            if (tick) begin
               if (q.cnt == 5'(LEAD_TICKS - 1)) begin
                  d.st = ST_CONV;
                  d.cnt = 5'h0;
               end else begin
                  d.cnt = 5'(q.cnt + 5'h1);
               end
            end
         end
         ST_CONV: begin
            if (tick) begin
               sar.clr = (q.cnt == 5'h0);
               if ((q.cnt >= 5'(SAMPLE_TICKS))
                   && (q.cnt < 5'(SAMPLE_TICKS + BIT_TICKS * DATA_W))) begin
                  sar.trial = !bit_off[0];
                  sar.decide = bit_off[0];
               end
               if (q.cnt == 5'(CONV_TICKS - 1)) begin
                  // RC clock is asynchronous to the bus: wait before updating
                  d.st = ST_SYNC;
                  d.cnt = 5'h0;
               end else begin
                  d.cnt = 5'(q.cnt + 5'h1);
               end
            end
         end
         ST_SYNC: begin
            d.cnt = 5'(q.cnt + 5'h1);
         end
      endcase

      // result update and the choice of what comes next
      if (conv_end) begin
         res.we = 1'h1;
         d.cnt = 5'h0;
         d.st = ST_CONV;
         if (q.idx == 2'(RES_NUM - 1)) begin
            d.done = 1'h1;
            d.idx = 2'h0;
            if (!q.scan) begin
               d.st = ST_IDLE;
            end
         end else begin
            d.idx = 2'(q.idx + 2'h1);
         end
      end

      if (wr_opt) begin
         d.opt = wr_data;
      end
      // a control write aborts and restarts; the old sequence cannot set the flag
      if (wr_ctl) begin
         res.we = 1'h0;
         d.scan = wr_data[CTL_SCAN_BIT];
         d.multi_channel_select = wr_data[CTL_MULTI_CHANNEL_SELECT_BIT];
         d.cs = wr_data[CTL_CS_LSB +: CS_W];
         d.done = 1'h0;
         d.st = ST_LEAD;
         d.cnt = 5'h0;
         d.idx = 2'h0;
      end

      // channel: group mode keeps the top select bits and walks the low two
      d.mux = d.multi_channel_select ? {d.cs[CS_W-1:2], d.idx} : d.cs;
      d.sample = (d.st == ST_CONV) && (d.cnt < 5'(SAMPLE_TICKS));
      d.busy = (d.st != ST_IDLE);
      d.since = wr_ctl ? 6'h0 : ((q.since == 6'h3f) ? q.since : 6'(q.since + 6'h1));
      d.rc_seen = wr_ctl ? wr_opt && wr_data[OPT_CLOCK_SOURCE_SELECT_BIT]
                         : q.rc_seen || q.opt[OPT_CLOCK_SOURCE_SELECT_BIT];
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= MAIN_RST;
      end else begin
         q <= d;
      end
   end

   assign rd_data = res.rdata;
   assign mux_chan_q = q.mux;
   assign sample_q = q.sample;
   assign dac_code = sar.code;
   assign pump_en_q = q.opt[OPT_PWR_BIT];
   assign pump_tick_q = q.pump_tick;
   assign nvm_pump_rc_q = q.opt[OPT_CLOCK_SOURCE_SELECT_BIT];
   assign busy_q = q.busy;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (!rst_b);

   property p_pwr;
      wr_opt |=> (pump_en_q == $past(wr_data[OPT_PWR_BIT]));
   endproperty
   a_pwr: assert property (p_pwr) else $error("pump enable not following power bit");

   property p_pump_tick;
      pump_tick_q |-> $past(q.opt[OPT_PWR_BIT]);
   endproperty
   a_pump_tick: assert property (p_pump_tick) else $error("pump clocked while off");

   property p_bus_clk;
      (q.opt[OPT_PWR_BIT] && !q.opt[OPT_CLOCK_SOURCE_SELECT_BIT]) [*2] |-> pump_tick_q;
   endproperty
   a_bus_clk: assert property (p_bus_clk) else $error("bus clock not driving pump");

   property p_nvm;
      wr_opt |=> (nvm_pump_rc_q == $past(wr_data[OPT_CLOCK_SOURCE_SELECT_BIT]));
   endproperty
   a_nvm: assert property (p_nvm) else $error("memory pump clock select wrong");

   property p_first;
      (conv_end && (q.idx == 2'h0) && !q.rc_seen && (q.since != 6'h3f))
         |-> (q.since == 6'(FIRST_RESULT_CYC - 1));
   endproperty
   a_first: assert property (p_first) else $error("first result at wrong cycle");

   property p_abort;
      wr_ctl |=> (!q.done && (q.st == ST_LEAD) && (q.idx == 2'h0));
   endproperty
   a_abort: assert property (p_abort) else $error("control write did not restart");

   property p_done;
      (conv_end && (q.idx == 2'h3) && !wr_ctl) |=> q.done ##1 (q.done || $past(wr_ctl));
   endproperty
   a_done: assert property (p_done) else $error("completion flag not set");

   property p_stop;
      (conv_end && (q.idx == 2'h3) && !q.scan && !wr_ctl) |=> (q.st == ST_IDLE) && !busy_q;
   endproperty
   a_stop: assert property (p_stop) else $error("single pass did not stop");

   property p_scan;
      (q.done && q.scan && !wr_ctl) |=> (q.done && (q.st != ST_IDLE));
   endproperty
   a_scan: assert property (p_scan) else $error("continuous mode dropped flag");

   property p_group;
      ((q.st == ST_CONV) && q.multi_channel_select) |-> (mux_chan_q == {q.cs[CS_W-1:2], q.idx});
   endproperty
   a_group: assert property (p_group) else $error("group channel wrong");

   property p_single;
      ((q.st == ST_CONV) && !q.multi_channel_select) |-> (mux_chan_q == q.cs);
   endproperty
   a_single: assert property (p_single) else $error("single channel wrong");

   property p_sync;
      (conv_end && q.opt[OPT_CLOCK_SOURCE_SELECT_BIT]) |-> ((q.st == ST_SYNC) && $past(q.st == ST_SYNC));
   endproperty
   a_sync: assert property (p_sync) else $error("RC update without sync wait");

   property p_bit6;
      (rd_stb && (addr == CTL_ADDR)) |=> (!rd_data[6] && (rd_data[7] == $past(q.done)));
   endproperty
   a_bit6: assert property (p_bit6) else $error("control status bits read wrong");

   property p_idle;
      (q.st == ST_IDLE) |-> (!sample_q && !busy_q);
   endproperty
   a_idle: assert property (p_idle) else $error("idle sequencer still active");

   property p_drop;
      wr_ctl |-> !res.we;
   endproperty
   a_drop: assert property (p_drop) else $error("result written during restart");

   property p_lead;
      (q.st == ST_LEAD) |-> (!sample_q && (q.cnt < 5'(LEAD_TICKS)));
   endproperty
   a_lead: assert property (p_lead) else $error("lead phase overran");

   property p_rd_hold;
      !rd_stb |=> $stable(rd_data);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved without a read");

   property p_mux_hold;
      (sample_q && $past(sample_q)) |-> $stable(mux_chan_q);
   endproperty
   a_mux_hold: assert property (p_mux_hold) else $error("channel changed while sampling");

   property p_clr;
      ((q.st == ST_CONV) && tick && (q.cnt == 5'h0)) |=> (dac_code == '0);
   endproperty
   a_clr: assert property (p_clr) else $error("trial code not cleared at start");

   property p_wrap;
      (conv_end && (q.idx == 2'h3) && q.scan && !wr_ctl) |=> ((q.st == ST_CONV) && (q.idx == 2'h0));
   endproperty
   a_wrap: assert property (p_wrap) else $error("continuous mode did not wrap");

   property p_opt_rd;
      (rd_stb && (addr == OPT_ADDR)) |=> (rd_data == $past(q.opt));
   endproperty
   a_opt_rd: assert property (p_opt_rd) else $error("options read back wrong");

   c_single: cover property (conv_end && (q.idx == 2'h3) && !q.scan);
   c_wrap: cover property (conv_end && (q.idx == 2'h3) && q.scan ##1 q.done);
   c_abort: cover property ((q.st == ST_CONV) && wr_ctl);
   c_rc: cover property ((q.st == ST_SYNC) && conv_end && q.multi_channel_select);
   c_group: cover property (conv_end && q.multi_channel_select && !q.opt[OPT_CLOCK_SOURCE_SELECT_BIT]);
endmodule : adcsq_top
`default_nettype wire

// *** rtl/adcsq_pkg.sv ***
// Purpose: shared constants and types of the converter sequencer control
// Assumes: 8-bit register port, 16-bit addresses, core_clk is the bus clock
// Notes:   timing figures are counted in converter clock ticks, except FIRST_RESULT_CYC and SYNC_CYC in core_clk cycles
package adcsq_pkg;
   localparam int ADDR_W = 16;
   localparam int DATA_W = 8;
   localparam int RES_NUM = 4;

   // register map
   localparam logic [ADDR_W-1:0] OPT_ADDR      = 16'h1039;
   localparam logic [ADDR_W-1:0] CTL_ADDR      = 16'h1030;
   localparam logic [ADDR_W-1:0] RES_BASE_ADDR = 16'h1031;

   // reset values
   localparam logic [DATA_W-1:0] OPT_RST = 8'h10;
   localparam logic [DATA_W-1:0] CTL_RST = 8'h00;

   // system options fields
   localparam int OPT_PWR_BIT  = 7;
   localparam int OPT_CLOCK_SOURCE_SELECT_BIT = 6;

   // conversion control fields
   localparam int CTL_DONE_BIT = 7;
   localparam int CTL_SCAN_BIT = 5;
   localparam int CTL_MULTI_CHANNEL_SELECT_BIT = 4;
   localparam int CTL_CS_LSB   = 0;
   localparam int CS_W         = 4;

   // conversion timing, in converter clock ticks; FIRST_RESULT_CYC and SYNC_CYC in core_clk cycles
   localparam int SAMPLE_TICKS     = 12;
   localparam int BIT_TICKS        = 2;
   localparam int CONV_TICKS       = 32;
   localparam int FIRST_RESULT_CYC = 34;
   // the first lead tick is the cycle after the write cycle, so lead plus one conversion is the first delay
   localparam int LEAD_TICKS       = FIRST_RESULT_CYC - CONV_TICKS;
   localparam int SYNC_CYC         = 2;

   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_LEAD = 4'h2,
      ST_CONV = 4'h4,
      ST_SYNC = 4'h8
   } adcsq_state_t;
endpackage : adcsq_pkg

// *** rtl/adcsq_if.sv ***
// Purpose: carriers between the sequencer and its result file and SAR
// Assumes: one clock domain
// Notes:   rdata of the result file is the bus read data flop
`timescale 1ns/100ps
`default_nettype none
interface adcsq_res_if;
   logic       we;
   logic [1:0] widx;
   logic [7:0] wdata;
   logic       rd_en;
   logic       rd_res;
   logic [1:0] ridx;
   logic [7:0] other;
   logic [7:0] rdata;
   modport seq (output we, widx, wdata, rd_en, rd_res, ridx, other, input rdata);
   modport mem (input we, widx, wdata, rd_en, rd_res, ridx, other, output rdata);
endinterface : adcsq_res_if

interface adcsq_sar_if;
   logic       clr;
   logic       trial;
   logic       decide;
   logic [2:0] bit_idx;
   logic       comp;
   logic [7:0] code;
   modport seq (output clr, trial, decide, bit_idx, comp, input code);
   modport sar (input clr, trial, decide, bit_idx, comp, output code);
endinterface : adcsq_sar_if
`default_nettype wire

// *** rtl/adcsq_results.sv ***
// Purpose: four 8-bit result words and the registered bus read data
// Assumes: writes come only from the sequencer
// Notes:   a read in the update cycle returns the word before the update
`timescale 1ns/100ps
`default_nettype none
module adcsq_results
   import adcsq_pkg::*;
(
   // clock and reset
   input wire logic   core_clk,
   input wire logic   rst_b,
   // sequencer side
   adcsq_res_if.mem   res
);
   typedef struct packed {
      logic [RES_NUM-1:0][DATA_W-1:0] mem;
      logic [DATA_W-1:0]              rdata;
   } adcsq_res_t;

   adcsq_res_t q;
   adcsq_res_t d;

   always_comb begin
      d = q;
      if (res.we) begin
         d.mem[res.widx] = res.wdata;
      end
      // read samples the old word so an update never tears a read
      if (res.rd_en) begin
         d.rdata = res.rd_res ? q.mem[res.ridx] : res.other;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign res.rdata = q.rdata;
endmodule : adcsq_results
`default_nettype wire

// *** rtl/adcsq_sar.sv ***
// Purpose: successive-approximation code register
// Assumes: comp is high when the input lies below the trial code
// Notes:   trial sets the bit under test, decide keeps or drops it
`timescale 1ns/100ps
`default_nettype none
module adcsq_sar
   import adcsq_pkg::*;
(
   // clock and reset
   input wire logic   core_clk,
   input wire logic   rst_b,
   // sequencer side
   adcsq_sar_if.sar   sar
);
   typedef struct packed {
      logic [DATA_W-1:0] code;
   } adcsq_sar_t;

   adcsq_sar_t q;
   adcsq_sar_t d;

   always_comb begin
      d = q;
      if (sar.clr) begin
         d.code = '0;
      end else if (sar.trial) begin
         d.code[sar.bit_idx] = 1'h1;
      end else if (sar.decide && sar.comp) begin
         d.code[sar.bit_idx] = 1'h0;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign sar.code = q.code;
endmodule : adcsq_sar
`default_nettype wire

// *** dv/adcsq_analog_model.sv ***
// Purpose: analog side of the converter: channel levels and comparator
// Assumes: comp_in is high while the held level lies below dac_code
// Notes:   channel c carries {c, c ^ 9} plus shift, tracked while sample_q is high, held while it is low
`timescale 1ns/100ps
`default_nettype none
module adcsq_analog_model (
   // multiplexer and array
   input  wire logic [3:0] mux_chan_q,
   input  wire logic       sample_q,
   input  wire logic [7:0] dac_code,
   input  wire logic [7:0] shift,
   // comparator
   output logic            comp_in
);
   logic [7:0] held;

   // the array keeps the charge taken during the sample window only
   always @(sample_q or mux_chan_q or shift) begin
      if (sample_q) begin
         held = {mux_chan_q, mux_chan_q ^ 4'h9} + shift;
      end
   end

   assign comp_in = (held < dac_code);
endmodule : adcsq_analog_model
`default_nettype wire

// *** dv/adcsq_top_test.sv ***
// Purpose: self-checking bench of the converter sequencer control
// Assumes: free running oscillator near 2 MHz, unrelated to core_clk
// Notes:   result words are checked against the channel levels of the model
`timescale 1ns/100ps
`default_nettype none
module adcsq_top_test
   import adcsq_pkg::*;
;
   typedef struct packed {
      logic [7:0]  ctl;
      logic [31:0] res;
   } adcsq_row_t;

   logic              core_clk      = 1'b0;
   logic              rst_b         = 1'b0;
   logic              rc_osc_clk    = 1'b0;
   logic              wr_stb        = 1'b0;
   logic              rd_stb        = 1'b0;
   logic [ADDR_W-1:0] addr          = 16'h0000;
   logic [DATA_W-1:0] wr_data       = 8'h00;
   logic [7:0]        shift         = 8'h00;
   logic [DATA_W-1:0] rd_data;
   logic [DATA_W-1:0] dac_code;
   logic [CS_W-1:0]   mux_chan_q;
   logic              comp_in;
   logic              sample_q;
   logic              pump_en_q;
   logic              pump_tick_q;
   logic              nvm_pump_rc_q;
   logic              busy_q;
   int                failures      = 0;
   int                comparisons   = 0;
   int                bad_ticks     = 0;
   int                good_ticks    = 0;
   adcsq_row_t        rows [5]      = '{'{8'h05, 32'h5c5c5c5c}, '{8'h16, 32'h4d5c6f7e},
                                        '{8'h1b, 32'h8190a3b2}, '{8'h0f, 32'hf6f6f6f6},
                                        '{8'h13, 32'h09182b3a}};

   always #20 core_clk = ~core_clk;
   always #251 rc_osc_clk <= ~rc_osc_clk;

   always @(posedge core_clk) begin
      if (rst_b && pump_tick_q) begin
         if (pump_en_q) good_ticks++;
         else bad_ticks++;
      end
   end

   adcsq_top adcsq_top_i (
      .core_clk      (core_clk),
      .rst_b         (rst_b),
      .addr          (addr),
      .wr_data       (wr_data),
      .wr_stb        (wr_stb),
      .rd_stb        (rd_stb),
      .rd_data       (rd_data),
      .rc_osc_clk    (rc_osc_clk),
      .comp_in       (comp_in),
      .mux_chan_q    (mux_chan_q),
      .sample_q      (sample_q),
      .dac_code      (dac_code),
      .pump_en_q     (pump_en_q),
      .pump_tick_q   (pump_tick_q),
      .nvm_pump_rc_q (nvm_pump_rc_q),
      .busy_q        (busy_q)
   );

   adcsq_analog_model adcsq_analog_model_i (
      .mux_chan_q (mux_chan_q),
      .sample_q   (sample_q),
      .dac_code   (dac_code),
      .shift      (shift),
      .comp_in    (comp_in)
   );

   task automatic chk8(input string name, input logic [7:0] e, input logic [7:0] g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", name, e, g);
      end
   endtask : chk8

   task automatic chk1(input string name, input logic e, input logic g);
      comparisons++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", name, e, g);
      end
   endtask : chk1

   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge core_clk);
      addr <= a;
      wr_data <= d;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask : wr

   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1 d = rd_data;
   endtask : rd

   task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [7:0] e, input string name);
      logic [7:0] v;
      rd(a, v);
      chk8(name, e, v);
   endtask : rdchk

   task automatic wait_done(input int tries);
      logic [7:0] v;
      int         n;
      v = 8'h00;
      n = 0;
      while (v[CTL_DONE_BIT] !== 1'b1 && n < tries) begin
         rd(CTL_ADDR, v);
         n++;
      end
      chk1("completion flag", 1'b1, v[CTL_DONE_BIT]);
   endtask : wait_done

   task automatic wrap_up();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : wrap_up

   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      wrap_up();
   end

   initial begin
      repeat (4) @(posedge core_clk);
      rst_b <= 1'b1;
      @(posedge core_clk);
      #1;
      chk1("pump enable at reset", 1'b0, pump_en_q);
      chk1("busy at reset", 1'b0, busy_q);
      rdchk(OPT_ADDR, 8'h10, "options reset");
      rdchk(CTL_ADDR, 8'h00, "control reset");
      // a sequence run unpowered must leave the pump unclocked
      wr(CTL_ADDR, 8'h00);
      repeat (60) @(posedge core_clk);
      chk8("unpowered pump ticks", 8'h00, bad_ticks[7:0]);
      wr(OPT_ADDR, 8'h85);
      repeat (20) @(posedge core_clk);
      chk1("pump enable", 1'b1, pump_en_q);
      chk1("memory pump on rc", 1'b0, nvm_pump_rc_q);
      rdchk(OPT_ADDR, 8'h85, "options readback");
      foreach (rows[i]) begin
         wr(CTL_ADDR, rows[i].ctl);
         rdchk(CTL_ADDR, rows[i].ctl & 8'h3f, "control at start");
         wait_done(80);
         for (int k = 0; k < 4; k++) begin
            rdchk(RES_BASE_ADDR + ADDR_W'(k), rows[i].res[31-8*k -: 8], "res");
         end
         chk1("stopped after one pass", 1'b0, busy_q);
      end
      chk1("pump clocked by converter", 1'b1, good_ticks > 0);
      // first result lands between strobe edges 33 and 35
      wr(CTL_ADDR, 8'h05);
      repeat (31) @(posedge core_clk);
      rdchk(RES_BASE_ADDR, 8'h09, "first result early");
      rdchk(RES_BASE_ADDR, 8'h5c, "first result on time");
      // abort in mid-sequence with the status bits written as ones
      wr(CTL_ADDR, 8'hd6);
      rdchk(CTL_ADDR, 8'h16, "control after abort");
      wait_done(80);
      rdchk(RES_BASE_ADDR, 8'h4d, "result after abort");
      wr(RES_BASE_ADDR, 8'h00);
      rdchk(RES_BASE_ADDR, 8'h4d, "result write ignored");
      rdchk(16'h1000, 8'h00, "unmapped read");
      wr(CTL_ADDR, 8'h22);
      wait_done(80);
      rdchk(RES_BASE_ADDR + 16'h0003, 8'h2b, "scan first pass");
      @(posedge core_clk);
      shift <= 8'h01;
      repeat (300) @(posedge core_clk);
      for (int k = 0; k < 4; k++) begin
         rdchk(RES_BASE_ADDR + ADDR_W'(k), 8'h2c, "scan overwrite");
      end
      rdchk(CTL_ADDR, 8'ha2, "flag kept in scan");
      chk1("scan busy", 1'b1, busy_q);
      wr(CTL_ADDR, 8'h02);
      rdchk(CTL_ADDR, 8'h02, "scan abort clears flag");
      wait_done(80);
      shift <= 8'h00;
      wr(OPT_ADDR, 8'hc0);
      repeat (40) @(posedge core_clk);
      chk1("memory pump on rc", 1'b1, nvm_pump_rc_q);
      wr(CTL_ADDR, 8'h13);
      repeat (140) @(posedge core_clk);
      rdchk(CTL_ADDR, 8'h13, "rc sequence still running");
      wait_done(1500);
      rdchk(RES_BASE_ADDR + 16'h0003, 8'h3a, "rc result");
      wrap_up();
   end
endmodule : adcsq_top_test
`default_nettype wire
